// ---- uhor_pkg.sv ----
// constants, field layouts and carrier types of the usb host operational register bank
// ==========================================================================
// Behaviour
// - two-bit functional state: 00 reset, 01 resume, 10 operational, 11 suspend.
// - control bit selects isochronous list processing; 0 means yes, 1 means no.
// - control bit 8 routes interrupts: 0 normal line, 1 system management.
// - writing 1 to reset bit starts soft reset; hardware clears it afterwards.
// - list-filled bits set by software only, cleared by hardware at list head start.
// - software setting ownership request sets the ownership change flag, bit 30.
// - root hub status change flag set whenever hub or port status changes.
// - frame number overflow flag set whenever frame number bit 15 toggles.
// - unrecoverable error flag and its enable bits read 0, ignore writes.
// - resume detected flag set on resume signaling at any downstream port.
// - start-of-frame flag set at every new frame start.
// - done-head writeback flag set after done head written to host memory.
// - status register: write 1 clears a flag, write 0 leaves it.
// - enable register: write 1 sets an enable, write 0 leaves it.
// - top enable bit is master enable gating all sources.
// - disable register: write 1 clears matching enable, master bit included.
// - frame interval field bits 13:0 holds length minus one, resets to 2EDF.
// - largest data packet counter loads from interval bits 30:16 each frame.
// - 14-bit remaining counter decrements per bit-clock tick while operational.
// - counter reloads from interval at zero and on entering operational.
// - every counter load copies interval toggle into remaining toggle bit 31.
// - 16-bit frame number advances whenever the remaining counter loads.
package uhor_pkg;

   // ==========================================================================
   // register byte offsets
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  OFS_REVISION  = 8'h00;
   localparam logic [7:0]  OFS_CONTROL   = 8'h04;
   localparam logic [7:0]  OFS_CMDSTAT   = 8'h08;
   localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0C;
   localparam logic [7:0]  OFS_IRQ_SET   = 8'h10;
   localparam logic [7:0]  OFS_IRQ_CLR   = 8'h14;
   localparam logic [7:0]  OFS_COMM_AREA = 8'h18;
   localparam logic [7:0]  OFS_PER_CUR   = 8'h1C;
   localparam logic [7:0]  OFS_CTL_HEAD  = 8'h20;
   localparam logic [7:0]  OFS_CTL_CUR   = 8'h24;
   localparam logic [7:0]  OFS_BLK_HEAD  = 8'h28;
   localparam logic [7:0]  OFS_BLK_CUR   = 8'h2C;
   localparam logic [7:0]  OFS_DONE_HEAD = 8'h30;
   localparam logic [7:0]  OFS_FRM_CFG   = 8'h34;
   localparam logic [7:0]  OFS_FRM_CNT   = 8'h38;

   // ==========================================================================
   // reset values and field masks
   localparam logic [31:0] REVISION_VAL  = 32'h0000_0010;
   localparam logic [13:0] FI_RESET      = 14'h2EDF;
   localparam logic [31:0] STS_MASK      = 32'h4000_006F;  // flag bits, error bit 4 excluded
   localparam logic [31:0] ENA_MASK      = 32'hC000_006F;  // enables plus master bit 31
   localparam int          MASTER_BIT    = 31;
   localparam int          SO_BIT        = 0;
   localparam int          WDH_BIT       = 1;
   localparam int          SF_BIT        = 2;
   localparam int          RD_BIT        = 3;
   localparam int          FNO_BIT       = 5;
   localparam int          RHSC_BIT      = 6;
   localparam int          OC_BIT        = 30;
   localparam int          FNUM_TOP      = 15;

   // ==========================================================================
   // soft reset duration
   localparam int          CLK_PERIOD_NS = 100;
   localparam int          SRST_TIME_NS  = 10000;
   localparam int          SRST_CYCLES   = SRST_TIME_NS / CLK_PERIOD_NS;  // longest, round down
   localparam logic [7:0]  SRST_LAST     = 8'(SRST_CYCLES - 1);

   // functional state encoding
   typedef enum logic [1:0] {
      FS_RESET  = 2'h0,
      FS_RESUME = 2'h1,
      FS_OPER   = 2'h2,
      FS_SUSP   = 2'h3
   } uhor_fstate_t;

   // soft reset sequencer, one-hot
   typedef enum logic [1:0] {
      SQ_IDLE = 2'h1,
      SQ_RST  = 2'h2
   } uhor_seq_t;

   // events from list processor, root hub and bit clock logic
   typedef struct packed {
      logic          sched_overrun;    // frame overrun pulse
      logic          done_head_written;// done head stored in host memory
      logic          resume_detect;    // resume seen on a downstream port
      logic          rh_change;        // root hub or port status changed
      logic          ctrl_head_start;  // control list head processing begun
      logic          bulk_head_start;  // bulk list head processing begun
      logic          fs_req_valid;     // controller forces a state change
      uhor_fstate_t  fs_req_state;     // state to force
      logic          bit_tick;         // one pulse per 5 MHz bit period
   } uhor_events_t;

   // configuration and timing view for the list processor
   typedef struct packed {
      uhor_fstate_t  func_state;
      logic [1:0]    ctrl_bulk_ratio;
      logic          periodic_en;
      logic          iso_skip;
      logic          ctrl_list_en;
      logic          bulk_list_en;
      logic          ctrl_filled;
      logic          bulk_filled;
      logic          soft_reset;
      logic [23:0]   comm_area;
      logic [27:0]   periodic_cur;
      logic [27:0]   ctrl_head;
      logic [27:0]   ctrl_cur;
      logic [27:0]   bulk_head;
      logic [27:0]   bulk_cur;
      logic [27:0]   done_head;
      logic [14:0]   max_packet_cnt;
      logic [13:0]   frame_remain;
      logic [15:0]   frame_number;
      logic          frame_start;
   } uhor_cfg_t;

endpackage

// ---- uhor_regs.sv ----
// operational register bank with frame timer and interrupt gating
`timescale 1ns/1ps

module uhor_regs
   import uhor_pkg::*;
(
   input  wire logic               clk,        // 10 MHz system clock
   input  wire logic               rst_n,      // asynchronous reset, active low
   input  wire logic               reg_wr,     // register write strobe
   input  wire logic               reg_rd,     // register read strobe
   input  wire logic [ADDR_W-1:0]  reg_addr,   // byte offset of the register
   input  wire logic [3:0]         reg_be,     // byte enables of the write
   input  wire logic [31:0]        reg_wdata,  // write data
   output      logic [31:0]        reg_rdata,  // read data, one cycle after reg_rd
   input  wire uhor_events_t       ev,         // hardware events, same clock
   output      uhor_cfg_t          cfg,        // register view for the core
   output      logic               irq_pci,    // interrupt on normal line
   output      logic               irq_smi     // interrupt on management path
);

   // ==========================================================================
   // state
   typedef struct packed {
      // sequencer
      uhor_seq_t     seq;
      logic [7:0]    rst_cnt;

      // control
      logic [1:0]    cbsr;
      logic          ple;
      logic          iso_off;
      logic          cle;
      logic          ble;
      uhor_fstate_t  fstate;
      logic          irq_route;

      // command
      logic          hc_reset;
      logic          clf;
      logic          blf;
      logic          own_req;
      logic [1:0]    so_cnt;

      // interrupts
      logic [31:0]   sts;
      logic [31:0]   ena;

      // pointers
      logic [23:0]   hcca;
      logic [27:0]   per_cur;
      logic [27:0]   ctl_head;
      logic [27:0]   ctl_cur;
      logic [27:0]   blk_head;
      logic [27:0]   blk_cur;
      logic [27:0]   done_head;

      // frame timer
      logic [13:0]   fi;
      logic [14:0]   fsmps;
      logic          fit;
      logic [13:0]   frem;
      logic          frt;
      logic [15:0]   fnum;
      logic [14:0]   ldp;
      logic          sof;

      // outputs
      logic [31:0]   rdata;
      logic          irq_pci;
      logic          irq_smi;
   } uhor_state_t;

   // frame interval default and idle sequencer; every other field clears
   // soft reset reuses this image
   // so both resets agree apart from read data
   localparam uhor_state_t RESET_STATE = '{seq: SQ_IDLE, fstate: FS_RESET, fi: FI_RESET,
                                          default: '0};

   uhor_state_t s_r;
   uhor_state_t s_nxt;

   // ==========================================================================
   // helpers
   // a lane with its enable low keeps its bits
   // so no read-modify-write is needed
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   // shared by write and read paths
   logic [31:0] wmask;
   logic [31:0] wd;
   logic [31:0] ctrl_rd;
   logic [31:0] cmd_rd;
   logic [31:0] frm_cfg_rd;
   logic [31:0] frm_cnt_rd;

   // byte enables widen to a bit mask
   assign wmask = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}};
   assign wd    = reg_wdata & wmask;

   // read images; remote wakeup bits hardwired to zero as no such signal exists
   // reserved bits read zero
   assign ctrl_rd    = {23'h0, s_r.irq_route, s_r.fstate, s_r.ble, s_r.cle,
                        s_r.iso_off, s_r.ple, s_r.cbsr};
   assign cmd_rd     = {14'h0, s_r.so_cnt, 12'h0, s_r.own_req, s_r.blf, s_r.clf,
                        s_r.hc_reset};
   assign frm_cfg_rd = {s_r.fit, s_r.fsmps, 2'h0, s_r.fi};
   assign frm_cnt_rd = {s_r.frt, 17'h0, s_r.frem};

   // ==========================================================================
   // next-state logic
   always_comb
   begin
      // scratch, set at the top
      logic [31:0]  c;
      logic [31:0]  set_v;
      logic         frm_load;
      logic         pend;
      c        = '0;
      set_v    = '0;
      frm_load = 1'b0;
      pend     = 1'b0;
      s_nxt    = s_r;
      s_nxt.sof = 1'b0;

      // register writes
      // read-only offsets hit default
      if (reg_wr)
      begin
         case (reg_addr)
            OFS_CONTROL:
            begin
               c = merge(ctrl_rd, reg_wdata, wmask);
               s_nxt.cbsr      = c[1:0];
               s_nxt.ple       = c[2];
               s_nxt.iso_off   = c[3];
               s_nxt.cle       = c[4];
               s_nxt.ble       = c[5];
               s_nxt.fstate    = uhor_fstate_t'(c[7:6]);
               s_nxt.irq_route = c[8];
            end
            OFS_CMDSTAT:
            begin
               if (wd[0])
                  s_nxt.hc_reset = 1'b1;
               // ownership request is plain rw
               if (reg_be[0])
                  s_nxt.own_req = reg_wdata[3];
            end
            OFS_COMM_AREA:
            begin
               // low byte reserved
               s_nxt.hcca = 24'(merge({s_r.hcca, 8'h0}, reg_wdata, wmask) >> 8);
            end
            OFS_PER_CUR:   s_nxt.per_cur   = 28'(merge({s_r.per_cur, 4'h0}, reg_wdata, wmask) >> 4);
            OFS_CTL_HEAD:  s_nxt.ctl_head  = 28'(merge({s_r.ctl_head, 4'h0}, reg_wdata, wmask) >> 4);
            OFS_CTL_CUR:   s_nxt.ctl_cur   = 28'(merge({s_r.ctl_cur, 4'h0}, reg_wdata, wmask) >> 4);
            OFS_BLK_HEAD:  s_nxt.blk_head  = 28'(merge({s_r.blk_head, 4'h0}, reg_wdata, wmask) >> 4);
            OFS_BLK_CUR:   s_nxt.blk_cur   = 28'(merge({s_r.blk_cur, 4'h0}, reg_wdata, wmask) >> 4);
            OFS_DONE_HEAD: s_nxt.done_head = 28'(merge({s_r.done_head, 4'h0}, reg_wdata, wmask) >> 4);
            OFS_FRM_CFG:
            begin
               // interval field
               // bits 15:14 reserved
               c = merge(frm_cfg_rd, reg_wdata, wmask);
               s_nxt.fi    = c[13:0];
               s_nxt.fsmps = c[30:16];
               // toggle kept as written by the driver
               s_nxt.fit   = c[31];
            end
            // one store behind both offsets
            OFS_IRQ_SET:
               // error enable bit excluded by mask
               s_nxt.ena = s_r.ena | (wd & ENA_MASK);
            OFS_IRQ_CLR:
               s_nxt.ena = s_r.ena & ~(wd & ENA_MASK);
            default: ;
         endcase
      end

      // ownership request raises its flag
      // from write data, so a repeat raises it again
      if (reg_wr && reg_addr == OFS_CMDSTAT && wd[3])
         set_v[OC_BIT] = 1'b1;

      // hardware clears list-filled; a software set in the same cycle wins
      // set applied last so it is never lost
      s_nxt.clf = (s_r.clf & ~ev.ctrl_head_start);
      s_nxt.blf = (s_r.blf & ~ev.bulk_head_start);
      if (reg_wr && reg_addr == OFS_CMDSTAT && wd[1])
         s_nxt.clf = 1'b1;
      if (reg_wr && reg_addr == OFS_CMDSTAT && wd[2])
         s_nxt.blf = 1'b1;

      // controller forces its own state, overriding software
      // hardware wins over software
      if (ev.fs_req_valid)
         s_nxt.fstate = ev.fs_req_state;

      // frame timer
      // entry uses the next state, so the first
      // frame starts on the state change edge
      if (s_nxt.fstate == FS_OPER && s_r.fstate != FS_OPER)
         frm_load = 1'b1;
      else if (s_r.fstate == FS_OPER && ev.bit_tick)
      begin
         // count down per bit tick
         // zero is the last bit time
         if (s_r.frem == 14'h0)
            frm_load = 1'b1;
         else
            s_nxt.frem = s_r.frem - 14'h1;
      end
      if (frm_load)
      begin
         s_nxt.frem = s_r.fi;
         s_nxt.frt  = s_r.fit;
         // frame number advances with the load
         s_nxt.fnum = s_r.fnum + 16'h1;
         s_nxt.ldp  = s_r.fsmps;
         // start pulse for the list processor
         s_nxt.sof  = 1'b1;
         set_v[SF_BIT] = 1'b1;
         // top bit toggles either way
         // compared across the load
         if (s_nxt.fnum[FNUM_TOP] != s_r.fnum[FNUM_TOP])
            set_v[FNO_BIT] = 1'b1;
      end

      // overrun counts and flags
      // two bits, wraps freely
      if (ev.sched_overrun)
      begin
         s_nxt.so_cnt  = s_r.so_cnt + 2'h1;
         set_v[SO_BIT] = 1'b1;
      end

      set_v[WDH_BIT]  = ev.done_head_written;
      set_v[RD_BIT]   = ev.resume_detect;
      set_v[RHSC_BIT] = ev.rh_change;

      // write one clears; a coincident event keeps the flag set
      // error flag never stored
      // events or-ed after the clear, none lost
      if (reg_wr && reg_addr == OFS_IRQ_STAT)
         s_nxt.sts = (s_r.sts & ~wd & STS_MASK) | set_v;
      else
         s_nxt.sts = (s_r.sts & STS_MASK) | set_v;

      // registered outputs keep glitches
      // off both interrupt paths
      // master enable gates all sources
      pend = (|(s_r.sts & s_r.ena & STS_MASK)) & s_r.ena[MASTER_BIT];
      s_nxt.irq_pci = pend & ~s_r.irq_route;
      s_nxt.irq_smi = pend & s_r.irq_route;

      // register reads, unmapped offsets return zero
      // read data holds until the next read
      if (reg_rd)
      begin
         case (reg_addr)
            OFS_REVISION:  s_nxt.rdata = REVISION_VAL;
            OFS_CONTROL:   s_nxt.rdata = ctrl_rd;
            OFS_CMDSTAT:   s_nxt.rdata = cmd_rd;
            OFS_IRQ_STAT:  s_nxt.rdata = s_r.sts & STS_MASK;
            OFS_IRQ_SET:   s_nxt.rdata = s_r.ena & ENA_MASK;
            OFS_IRQ_CLR:   s_nxt.rdata = s_r.ena & ENA_MASK;
            OFS_COMM_AREA: s_nxt.rdata = {s_r.hcca, 8'h0};
            OFS_PER_CUR:   s_nxt.rdata = {s_r.per_cur, 4'h0};
            OFS_CTL_HEAD:  s_nxt.rdata = {s_r.ctl_head, 4'h0};
            OFS_CTL_CUR:   s_nxt.rdata = {s_r.ctl_cur, 4'h0};
            OFS_BLK_HEAD:  s_nxt.rdata = {s_r.blk_head, 4'h0};
            OFS_BLK_CUR:   s_nxt.rdata = {s_r.blk_cur, 4'h0};
            OFS_DONE_HEAD: s_nxt.rdata = {s_r.done_head, 4'h0};
            OFS_FRM_CFG:   s_nxt.rdata = frm_cfg_rd;
            OFS_FRM_CNT:   s_nxt.rdata = frm_cnt_rd;
            default:       s_nxt.rdata = 32'h0000_0000;
         endcase
      end

      // soft reset sequencer; register writes during the reset are lost
      // read data survives the reset
      case (s_r.seq)
         SQ_IDLE:
         begin
            // a written one starts the count
            if (s_nxt.hc_reset)
            begin
               s_nxt.seq     = SQ_RST;
               s_nxt.rst_cnt = 8'h0;
            end
         end

         SQ_RST:
         begin
            // self-clear once the reset ends
            // a hard reset also ends it
            if (s_r.rst_cnt == SRST_LAST)
            begin
               s_nxt       = RESET_STATE;
               s_nxt.rdata = s_r.rdata;
            end
            else
               s_nxt.rst_cnt = s_r.rst_cnt + 8'h1;
         end
         // illegal code recovers via reset image
         default: s_nxt = RESET_STATE;
      endcase
   end

   // ==========================================================================
   // state register
   // the only clocked process
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s_r <= RESET_STATE;
      else
         s_r <= s_nxt;
   end

   // ==========================================================================
   // outputs
   // each view comes from a flip-flop
   assign reg_rdata          = s_r.rdata;
   assign irq_pci            = s_r.irq_pci;
   assign irq_smi            = s_r.irq_smi;
   assign cfg.func_state     = s_r.fstate;
   assign cfg.ctrl_bulk_ratio= s_r.cbsr;
   assign cfg.periodic_en    = s_r.ple;
   assign cfg.iso_skip       = s_r.iso_off;
   assign cfg.ctrl_list_en   = s_r.cle;
   assign cfg.bulk_list_en   = s_r.ble;
   assign cfg.ctrl_filled    = s_r.clf;
   assign cfg.bulk_filled    = s_r.blf;
   assign cfg.soft_reset     = s_r.hc_reset;

   // pointers
   assign cfg.comm_area      = s_r.hcca;
   assign cfg.periodic_cur   = s_r.per_cur;
   assign cfg.ctrl_head      = s_r.ctl_head;
   assign cfg.ctrl_cur       = s_r.ctl_cur;
   assign cfg.bulk_head      = s_r.blk_head;
   assign cfg.bulk_cur       = s_r.blk_cur;
   assign cfg.done_head      = s_r.done_head;

   // frame timing
   assign cfg.max_packet_cnt = s_r.ldp;
   assign cfg.frame_remain   = s_r.frem;
   assign cfg.frame_number   = s_r.fnum;
   assign cfg.frame_start    = s_r.sof;

endmodule

// ---- uhor_regs_assertions.sv ----
// concurrent checks on the ports of the operational register bank
`timescale 1ns/1ps

module uhor_regs_assertions
   import uhor_pkg::*;
(
   input wire logic               clk,        // system clock
   input wire logic               rst_n,      // reset, active low
   input wire logic               reg_wr,     // write strobe
   input wire logic               reg_rd,     // read strobe
   input wire logic [ADDR_W-1:0]  reg_addr,   // byte offset
   input wire logic [3:0]         reg_be,     // byte enables
   input wire logic [31:0]        reg_wdata,  // write data
   input wire logic [31:0]        reg_rdata,  // read data
   input wire uhor_events_t       ev,         // core events
   input wire uhor_cfg_t          cfg,        // register view
   input wire logic               irq_pci,    // normal interrupt
   input wire logic               irq_smi     // management interrupt
);
   // ==========================================================================
   // helpers: writes and forced state changes may move the timer, so skip them
   logic opr;
   logic quiet;
   assign opr   = cfg.func_state == FS_OPER;
   assign quiet = !reg_wr && !ev.fs_req_valid && !cfg.soft_reset;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_frem_count_down: assert property (
      opr && $past(opr) && quiet && ev.bit_tick && cfg.frame_remain != 14'h0
      |=> cfg.frame_remain == $past(cfg.frame_remain) - 14'h1) else $error("no decrement");
   a_frame_wrap: assert property (
      opr && $past(opr) && quiet && ev.bit_tick && cfg.frame_remain == 14'h0
      |=> cfg.frame_number == $past(cfg.frame_number) + 16'h1) else $error("no advance");
   a_sof_pulse: assert property (
      opr && $past(opr) && quiet && ev.bit_tick && cfg.frame_remain == 14'h0
      |-> ##[1:2] cfg.frame_start) else $error("no frame start");
   a_entry_load: assert property (
      $rose(opr) && !cfg.soft_reset |-> ##[0:1] $changed(cfg.frame_number))
      else $error("no load on entry");
   a_idle_hold: assert property (
      (!opr && !cfg.soft_reset) [*2] |-> $stable(cfg.frame_remain)) else $error("idle count");
   a_irq_one_path: assert property (
      !(irq_pci && irq_smi)) else $error("both interrupt paths");
   a_rev_read: assert property (
      reg_rd && reg_addr == OFS_REVISION && !cfg.soft_reset
      |=> reg_rdata == REVISION_VAL) else $error("revision value");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr > OFS_FRM_CNT && !cfg.soft_reset
      |=> reg_rdata == 32'h0) else $error("unmapped read");
   a_srst_holds: assert property (
      $rose(cfg.soft_reset) |-> cfg.soft_reset [*8]) else $error("reset too short");
   a_srst_ends: assert property (
      $rose(cfg.soft_reset) |-> ##[8:120] !cfg.soft_reset) else $error("reset stuck");
   a_list_cleared: assert property (
      ev.ctrl_head_start && !reg_wr && !cfg.soft_reset |=> !cfg.ctrl_filled)
      else $error("filled not cleared");
endmodule

bind uhor_regs uhor_regs_assertions i_uhor_regs_assertions (.clk, .rst_n, .reg_wr, .reg_rd,
   .reg_addr, .reg_be, .reg_wdata, .reg_rdata, .ev, .cfg, .irq_pci, .irq_smi);

// ---- uhor_core_model.sv ----
// behavioural list processor and bit clock feeding events to the register bank
`timescale 1ns/1ps

module uhor_core_model
   import uhor_pkg::*;
#(
   parameter int TICK_DIV = 2  // cycles per bit tick; the bit clock cannot beat clk
)(
   input  wire logic          clk,    // system clock
   input  wire logic          rst_n,  // reset, active low
   input  wire uhor_cfg_t     cfg,    // register view
   input  wire logic [3:0]    fire,   // overrun, done head, resume, hub change
   output      uhor_events_t  ev      // event pulses
);
   // ==========================================================================
   // event generation
   logic [7:0] div_r;

   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         div_r <= 8'h00;
         ev    <= '0;
      end
      else
      begin
         div_r       <= (div_r == 8'(TICK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
         ev.bit_tick <= div_r == 8'h00;
         ev.ctrl_head_start <= cfg.ctrl_filled && !ev.ctrl_head_start;
         ev.bulk_head_start <= cfg.bulk_filled && !ev.bulk_head_start;
         {ev.sched_overrun, ev.done_head_written, ev.resume_detect, ev.rh_change} <= fire;
         // resume seen while suspended forces the resume state
         ev.fs_req_valid <= fire[1] && cfg.func_state == FS_SUSP;
         ev.fs_req_state <= FS_RESUME;
      end
endmodule

// ---- test_usb_host_operational_regs.sv ----
// self-checking testbench of the operational register bank
`timescale 1ns/1ps

module test_usb_host_operational_regs
   import uhor_pkg::*;
;
   logic          clk       = 1'b0;
   logic          rst_n     = 1'b0;
   logic          reg_wr    = 1'b0;
   logic          reg_rd    = 1'b0;
   logic [7:0]    reg_addr  = 8'h00;
   logic [3:0]    reg_be    = 4'hF;
   logic [31:0]   reg_wdata = 32'h0;
   logic [31:0]   reg_rdata;
   logic [3:0]    fire      = 4'h0;
   logic [31:0]   rv;
   logic          irq_pci;
   logic          irq_smi;
   uhor_events_t  ev;
   uhor_cfg_t     cfg;
   int            err_count = 0;
   int            samples_checked = 0;
   int            i;

   always #50 clk = ~clk;

   uhor_regs i_uhor_regs (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .ev(ev), .cfg(cfg), .irq_pci(irq_pci), .irq_smi(irq_smi));
   uhor_core_model i_uhor_core_model (.clk(clk), .rst_n(rst_n), .cfg(cfg), .fire(fire),
      .ev(ev));

   // ==========================================================================
   // bus tasks; each leaves an idle edge so strobes are never set twice at once
   task automatic finish_test;
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      reg_be    <= be;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      check(reg_rdata & m, exp);
   endtask

   // bounded wait: 0 normal interrupt, 1 management interrupt, 2 soft reset done
   task automatic wait_for(input int sel);
      int n;
      for (n = 0; n < 200 && (sel == 0 ? irq_pci : sel == 1 ? irq_smi : !cfg.soft_reset)
           !== 1'b1; n++)
         @(posedge clk);
      check(32'(n < 200), 32'h1);
      if (n == 200)
         finish_test();
   endtask

   // ==========================================================================
   // main sequence
   initial
   begin
      void'($urandom(32'hA209F2AA));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 16; i++)
         rd(8'(i * 4), i == 0 ? REVISION_VAL : i == 13 ? 32'h2EDF : 32'h0, '1);
      wr(OFS_REVISION, 32'hFFFF_FFFF);
      rd(OFS_REVISION, REVISION_VAL, '1);
      for (i = 7; i < 13; i++)
      begin
         rv = $urandom;
         wr(8'(i * 4), rv);
         rd(8'(i * 4), rv & 32'hFFFF_FFF0, '1);
      end
      wr(OFS_CTL_HEAD, 32'h0);
      wr(OFS_CTL_HEAD, 32'hFFFF_FFFF, 4'h2);
      rd(OFS_CTL_HEAD, 32'h0000_FF00, '1);
      for (i = 0; i < 4; i++)
      begin
         wr(OFS_CONTROL, (32'(i) << 6) | 32'h0000_013F);
         rd(OFS_CONTROL, (32'(i) << 6) | 32'h0000_013F, 32'h0000_01FF);
      end
      // short frames so several pass quickly; toggle flipped with the new length
      wr(OFS_FRM_CFG, 32'h8123_0014);
      wr(OFS_IRQ_SET, 32'h0000_0014);
      rd(OFS_IRQ_SET, 32'h0000_0004, '1);
      wr(OFS_CONTROL, 32'h0000_0080);
      repeat (100) @(posedge clk);
      check(32'({irq_pci, irq_smi}), 32'h0);
      rd(OFS_FRM_CNT, 32'h8000_0000, 32'hFFFF_C000);
      check(32'(cfg.max_packet_cnt), 32'h0000_0123);
      wr(OFS_IRQ_SET, 32'h8000_0000);
      wait_for(0);
      rd(OFS_IRQ_STAT, 32'h0000_0004, 32'h0000_0014);
      wr(OFS_CONTROL, 32'h0000_0180);
      wait_for(1);
      wr(OFS_IRQ_CLR, 32'h8000_0000);
      repeat (3) @(posedge clk);
      check(32'({irq_pci, irq_smi}), 32'h0);
      rd(OFS_IRQ_CLR, 32'h0000_0004, '1);
      wr(OFS_CONTROL, 32'h0);
      wr(OFS_IRQ_STAT, 32'h0);
      rd(OFS_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
      wr(OFS_IRQ_STAT, 32'hFFFF_FFFF);
      rd(OFS_IRQ_STAT, 32'h0, '1);
      wr(OFS_CONTROL, 32'h0000_00C0);
      wr(OFS_CMDSTAT, 32'h0000_0008);
      fire <= 4'hF;
      @(posedge clk);
      fire <= 4'h0;
      repeat (2) @(posedge clk);
      rd(OFS_IRQ_STAT, 32'h4000_004B, '1);
      rd(OFS_CMDSTAT, 32'h0001_0008, 32'h0003_0008);
      rd(OFS_CONTROL, 32'h0000_0040, 32'h0000_00C0);
      wr(OFS_CMDSTAT, 32'h0000_0006);
      repeat (3) @(posedge clk);
      rd(OFS_CMDSTAT, 32'h0, 32'h0000_0006);
      wr(OFS_CMDSTAT, 32'h0000_0001);
      check(32'(cfg.soft_reset), 32'h1);
      wait_for(2);
      rd(OFS_FRM_CFG, 32'h0000_2EDF, '1);
      rd(OFS_CMDSTAT, 32'h0, '1);
      finish_test();
   end
endmodule
